// ==== rtl/psp_defines.svh ====
// register offsets, field positions, reset values and phase codes of the host port
`ifndef PSP_DEFINES_SVH
`define PSP_DEFINES_SVH

// ************************************************************
// register offsets
// ************************************************************
`define ADDR_DATA_PORT   8'h08
`define ADDR_PORT_E      8'h09
`define ADDR_IRQ_STATUS  8'h0C
`define ADDR_DATA_DIR    8'h88
`define ADDR_STATUS      8'h89
`define ADDR_IRQ_MASK    8'h8C

// ************************************************************
// status register fields
// ************************************************************
`define BIT_IN_FULL      7
`define BIT_OUT_FULL     6
`define BIT_OVERRUN      5
`define BIT_HOST_SEL     4
`define BIT_UNUSED       3
`define DIR_MSB          2
`define BIT_PIN_CS       2
`define BIT_PIN_WR       1
`define BIT_PIN_RD       0

// ************************************************************
// reset values and irq field
// ************************************************************
`define DIR_CTRL_RESET   3'h7
`define DIR_DATA_RESET   8'hFF
`define BYTE_ZERO        8'h00
`define CTRL_ZERO        3'h0
`define BIT_IRQ_DONE     7

// ************************************************************
// quarter-cycle phase codes
// ************************************************************
`define PHASE_TWO        2'h1
`define PHASE_FOUR       2'h3
`define PHASE_STEP       2'h1
`define PHASE_RESET      2'h0

`endif

// ==== rtl/psp_pkg.sv ====
// types shared by the host port controller
package psp_pkg;

   // completion sequencer: release seen, wait phase two, then phase four
   typedef enum logic [1:0] {
      SEQ_IDLE      = 2'b00,
      SEQ_WAIT_TWO  = 2'b01,
      SEQ_WAIT_FOUR = 2'b10
   } done_seq_e;

   typedef logic [7:0] byte_t;

endpackage

// ==== rtl/parallel_slave_port_ctrl.sv ====
// parallel slave port controller with status, direction and completion interrupt
//
// Function
// R1 - in-full flag set on unread received byte
// R2 - out-full flag high until host reads
// R3 - overrun on write over unread byte
// R4 - three control pin directions, reset inputs
// R5 - status bit three reads zero
// R6 - read strobe with select drives latch
// R7 - write strobe with select captures bus
// R8 - strobes ignored while select high
// R9 - slave mode only while select bit set
// R10 - in-full and irq on phase four
// R11 - out-full cleared at read start
// R12 - in-full and out-full flags held clear outside slave mode
// R13 - strobes synchronised before edge detection
`timescale 1ns/1ps
`default_nettype none
`include "psp_defines.svh"

module parallel_slave_port_ctrl
   import psp_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   output logic            irq,
   input  wire logic [7:0] data_in,
   output logic      [7:0] data_out,
   output logic      [7:0] data_oe,
   input  wire logic [2:0] ctrl_pin_in,
   output logic      [2:0] ctrl_pin_out,
   output logic      [2:0] ctrl_pin_oe
);

   // both active-low lines asserted
   function automatic logic both_low(input logic a_n, input logic b_n);
      return ~a_n & ~b_n;
   endfunction

   // ************************************************************
   // register and state declarations
   // ************************************************************
   logic [2:0] ctrl_meta_reg;
   logic [2:0] ctrl_sync_reg;
   logic [7:0] data_meta_reg;
   logic [7:0] data_sync_reg;
   logic       wr_act_reg;
   logic       rd_act_reg;
   logic [1:0] phase_reg;
   done_seq_e  seq_reg;
   logic       seq_wr_reg;
   logic       seq_rd_reg;
   byte_t      in_latch_reg;
   byte_t      out_latch_reg;
   byte_t      data_dir_reg;
   logic [2:0] port_e_reg;
   logic [2:0] ctrl_dir_reg;
   logic       host_sel_reg;
   logic       in_full_reg;
   logic       out_full_reg;
   logic       overrun_reg;
   logic       irq_done_reg;
   logic       irq_mask_reg;
   byte_t      reg_rdata_reg;

   logic       cs_n;
   logic       wr_n;
   logic       rd_n;
   logic       wr_act;
   logic       rd_act;
   logic       wr_start;
   logic       rd_start;
   logic       wr_end;
   logic       rd_end;
   logic       phase_two;
   logic       phase_four;
   logic       done_wr;
   logic       done_rd;
   logic       sw_data_wr;
   logic       sw_data_rd;
   logic       sw_stat_wr;
   logic       sw_irq_rd;
   byte_t      status_view;

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   // R13 two-flop strobe sync
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl_meta_reg <= `DIR_CTRL_RESET;
         ctrl_sync_reg <= `DIR_CTRL_RESET;
      end else begin
         ctrl_meta_reg <= ctrl_pin_in;
         ctrl_sync_reg <= ctrl_meta_reg;
      end
   end

   // data bus sync, settles while the strobe is still low
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         data_meta_reg <= `BYTE_ZERO;
         data_sync_reg <= `BYTE_ZERO;
      end else begin
         data_meta_reg <= data_in;
         data_sync_reg <= data_meta_reg;
      end
   end

   assign cs_n = ctrl_sync_reg[`BIT_PIN_CS];
   assign wr_n = ctrl_sync_reg[`BIT_PIN_WR];
   assign rd_n = ctrl_sync_reg[`BIT_PIN_RD];

   // R8 select gates both strobes
   // R9 strobes are not decoded outside slave mode
   assign wr_act = host_sel_reg & both_low(cs_n, wr_n);
   assign rd_act = host_sel_reg & both_low(cs_n, rd_n);

   // edge-detected start and release of each strobe
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wr_act_reg <= 1'b0;
         rd_act_reg <= 1'b0;
      end else begin
         wr_act_reg <= wr_act;
         rd_act_reg <= rd_act;
      end
   end

   assign wr_start = wr_act & ~wr_act_reg;
   assign rd_start = rd_act & ~rd_act_reg;
   assign wr_end   = ~wr_act & wr_act_reg;
   assign rd_end   = ~rd_act & rd_act_reg;

   // ************************************************************
   // quarter-cycle phases and completion sequencer
   // ************************************************************
   // free-running phase counter, one phase per clock
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         phase_reg <= `PHASE_RESET;
      end else begin
         phase_reg <= phase_reg + `PHASE_STEP;
      end
   end

   assign phase_two  = (phase_reg == `PHASE_TWO);
   assign phase_four = (phase_reg == `PHASE_FOUR);

   // R10 release, next phase two, then phase four
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         seq_reg <= SEQ_IDLE;
      end else begin
         unique case (seq_reg)
            SEQ_IDLE: begin
               if (wr_end | rd_end) begin
                  seq_reg <= SEQ_WAIT_TWO;
               end
            end
            SEQ_WAIT_TWO: begin
               if (phase_two) begin
                  seq_reg <= SEQ_WAIT_FOUR;
               end
            end
            SEQ_WAIT_FOUR: begin
               if (phase_four) begin
                  seq_reg <= (wr_end | rd_end) ? SEQ_WAIT_TWO : SEQ_IDLE;
               end
            end
            default: begin
               seq_reg <= SEQ_IDLE;
            end
         endcase
      end
   end

   assign done_wr = (seq_reg == SEQ_WAIT_FOUR) & phase_four & seq_wr_reg;
   assign done_rd = (seq_reg == SEQ_WAIT_FOUR) & phase_four & seq_rd_reg;

   // which kinds of transfer are waiting to complete
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         seq_wr_reg <= 1'b0;
         seq_rd_reg <= 1'b0;
      end else if ((seq_reg == SEQ_WAIT_FOUR) & phase_four) begin
         seq_wr_reg <= wr_end;
         seq_rd_reg <= rd_end;
      end else begin
         seq_wr_reg <= seq_wr_reg | wr_end;
         seq_rd_reg <= seq_rd_reg | rd_end;
      end
   end

   // ************************************************************
   // software access decode
   // ************************************************************
   assign sw_data_wr = reg_wr & (reg_addr == `ADDR_DATA_PORT);
   assign sw_data_rd = reg_rd & (reg_addr == `ADDR_DATA_PORT);
   assign sw_stat_wr = reg_wr & (reg_addr == `ADDR_STATUS);
   assign sw_irq_rd  = reg_rd & (reg_addr == `ADDR_IRQ_STATUS);

   // ************************************************************
   // data latches
   // ************************************************************
   // R7 capture bus while write and select low
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         in_latch_reg <= `BYTE_ZERO;
      end else if (wr_act) begin
         in_latch_reg <= data_sync_reg;
      end
   end

   // firmware output latch, shared by both port modes
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         out_latch_reg <= `BYTE_ZERO;
      end else if (sw_data_wr) begin
         out_latch_reg <= reg_wdata;
      end
   end

   // ************************************************************
   // control registers
   // ************************************************************
   // R4 direction bits reset to inputs
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl_dir_reg <= `DIR_CTRL_RESET;
         host_sel_reg <= 1'b0;
      end else if (sw_stat_wr) begin
         ctrl_dir_reg <= reg_wdata[`DIR_MSB:0];
         host_sel_reg <= reg_wdata[`BIT_HOST_SEL];
      end
   end

   // general-purpose direction and control pin latch
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         data_dir_reg <= `DIR_DATA_RESET;
         port_e_reg   <= `CTRL_ZERO;
      end else begin
         if (reg_wr & (reg_addr == `ADDR_DATA_DIR)) begin
            data_dir_reg <= reg_wdata;
         end
         if (reg_wr & (reg_addr == `ADDR_PORT_E)) begin
            port_e_reg <= reg_wdata[`DIR_MSB:0];
         end
      end
   end

   // ************************************************************
   // status flags
   // ************************************************************
   // R1 R10 set on completion, cleared by latch read
   // R12 held clear outside slave mode
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         in_full_reg <= 1'b0;
      end else if (~host_sel_reg) begin
         in_full_reg <= 1'b0;
      end else if (done_wr) begin
         in_full_reg <= 1'b1;
      end else if (sw_data_rd) begin
         in_full_reg <= 1'b0;
      end
   end

   // R2 R11 firmware write sets, read start clears
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         out_full_reg <= 1'b0;
      end else if (~host_sel_reg) begin
         out_full_reg <= 1'b0;
      end else if (sw_data_wr) begin
         out_full_reg <= 1'b1;
      end else if (rd_start) begin
         out_full_reg <= 1'b0;
      end
   end

   // R3 write over unread byte, software zero clears
   // R12 survives leaving slave mode
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         overrun_reg <= 1'b0;
      end else if (wr_start & in_full_reg) begin
         overrun_reg <= 1'b1;
      end else if (sw_stat_wr & ~reg_wdata[`BIT_OVERRUN]) begin
         overrun_reg <= 1'b0;
      end
   end

   // ************************************************************
   // completion interrupt
   // ************************************************************
   // R10 sticky done flag, read of irq status clears, set wins
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_done_reg <= 1'b0;
      end else if (done_wr | done_rd) begin
         irq_done_reg <= 1'b1;
      end else if (sw_irq_rd) begin
         irq_done_reg <= 1'b0;
      end
   end

   // mask has the same layout as the irq status
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_mask_reg <= 1'b0;
      end else if (reg_wr & (reg_addr == `ADDR_IRQ_MASK)) begin
         irq_mask_reg <= reg_wdata[`BIT_IRQ_DONE];
      end
   end

   assign irq = irq_done_reg & irq_mask_reg;

   // ************************************************************
   // register read path
   // ************************************************************
   // R5 bit three left at zero
   always_comb begin
      status_view                = `BYTE_ZERO;
      status_view[`BIT_IN_FULL]  = in_full_reg;
      status_view[`BIT_OUT_FULL] = out_full_reg;
      status_view[`BIT_OVERRUN]  = overrun_reg;
      status_view[`BIT_HOST_SEL] = host_sel_reg;
      status_view[`DIR_MSB:0]    = ctrl_dir_reg;
   end

   // read data valid in the cycle after the strobe only
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata_reg <= `BYTE_ZERO;
      end else if (reg_rd) begin
         case (reg_addr)
            `ADDR_DATA_PORT:  reg_rdata_reg <= host_sel_reg ? in_latch_reg : data_sync_reg;
            `ADDR_PORT_E:     reg_rdata_reg <= {5'h00, ctrl_sync_reg};
            `ADDR_IRQ_STATUS: reg_rdata_reg <= {irq_done_reg, 7'h00};
            `ADDR_DATA_DIR:   reg_rdata_reg <= data_dir_reg;
            `ADDR_STATUS:     reg_rdata_reg <= status_view;
            `ADDR_IRQ_MASK:   reg_rdata_reg <= {irq_mask_reg, 7'h00};
            default:          reg_rdata_reg <= `BYTE_ZERO;
         endcase
      end else begin
         reg_rdata_reg <= `BYTE_ZERO;
      end
   end

   assign reg_rdata = reg_rdata_reg;

   // ************************************************************
   // pin drivers
   // ************************************************************
   // R6 drive latch during host read
   // data bus direction follows the host, not the direction register, in slave mode
   assign data_out = out_latch_reg;
   assign data_oe  = host_sel_reg ? {8{rd_act}} : ~data_dir_reg;

   // R4 zero bit drives the control pin
   // control pins are forced to inputs in slave mode to avoid bus contention
   assign ctrl_pin_out = port_e_reg;
   assign ctrl_pin_oe  = host_sel_reg ? `CTRL_ZERO : ~ctrl_dir_reg;

endmodule // parallel_slave_port_ctrl

`default_nettype wire

// ==== tb/host_cpu_model.sv ====
// behavioural external processor on the host port pins
`timescale 1ns/1ps
`default_nettype none

module host_cpu_model
   import psp_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic [7:0] data_out,
   input  wire logic [7:0] data_oe,
   output var  logic [2:0] ctrl_pin_in,
   output var  logic [7:0] data_in
);
   // ***************
   // host bus cycles
   // ***************
   // idle: all strobes high
   initial begin
      ctrl_pin_in = 3'h7;
      data_in     = 8'h00;
   end

   task automatic write_byte(input byte_t d, input logic sel);
      @(posedge sys_clk);
      ctrl_pin_in <= {~sel, 2'b01};
      data_in     <= d;
      // data held well past the sync delay
      repeat (5) @(posedge sys_clk);
      ctrl_pin_in <= 3'h7;
      // released bus must not look like the old byte
      data_in     <= ~d;
      repeat (10) @(posedge sys_clk);
   endtask

   task automatic read_byte(output byte_t q, output logic drv, input logic sel);
      @(posedge sys_clk);
      ctrl_pin_in <= {~sel, 2'b10};
      repeat (4) @(posedge sys_clk);
      #1;
      drv = (data_oe === 8'hFF);
      q   = data_out;
      @(posedge sys_clk);
      ctrl_pin_in <= 3'h7;
      repeat (10) @(posedge sys_clk);
   endtask
endmodule // host_cpu_model

`default_nettype wire

// ==== tb/parallel_slave_port_ctrl_chk.sv ====
// assertion checker for the host port controller
`timescale 1ns/1ps
`default_nettype none

module psp_ctrl_chk (
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [7:0] data_out,
   input wire logic [7:0] data_oe,
   input wire logic [2:0] ctrl_pin_in,
   input wire logic [2:0] ctrl_pin_oe
);
   // **********
   // properties
   // **********
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   // slave mode as last written, so bus enables in gpio mode are left alone
   logic sel_mode_reg;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sel_mode_reg <= 1'b0;
      end else if (reg_wr && reg_addr == 8'h89) begin
         sel_mode_reg <= reg_wdata[4];
      end
   end

   // status answer or write taken last cycle
   sequence stat_rd;
      $past(reg_rd) && $past(reg_addr) == 8'h89;
   endsequence
   sequence stat_wr;
      $past(reg_wr) && $past(reg_addr) == 8'h89;
   endsequence
   // select high long enough to pass the sync
   sequence sel_lost;
      ctrl_pin_in[2] [*3] ##0 (ctrl_pin_oe == 3'h0 && sel_mode_reg);
   endsequence

   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside answer cycle");
   a_bit3_zero: assert property (stat_rd |-> reg_rdata[3] == 1'b0)
      else $error("status bit three not zero");
   a_gpio_flags: assert property (
      stat_rd ##0 reg_rdata[4] == 1'b0 |-> reg_rdata[7:6] == 2'h0)
      else $error("full flags set outside slave mode");
   a_out_latch: assert property (
      $past(reg_wr) && $past(reg_addr) == 8'h08 |-> data_out == $past(reg_wdata))
      else $error("output latch not loaded");
   a_pins_slave: assert property (
      stat_wr ##0 $past(reg_wdata[4]) |-> ctrl_pin_oe == 3'h0)
      else $error("control pins driven in slave mode");
   a_pins_dir: assert property (
      stat_wr ##0 !$past(reg_wdata[4]) |-> ctrl_pin_oe == ~$past(reg_wdata[2:0]))
      else $error("control pin enables differ from direction");
   a_oe_start: assert property (
      $rose(data_oe == 8'hFF) && ctrl_pin_oe == 3'h0 && sel_mode_reg
      |-> $past(ctrl_pin_in[0] | ctrl_pin_in[2], 2) == 1'b0)
      else $error("bus driven without select and read");
   a_oe_stop: assert property (sel_lost |-> data_oe != 8'hFF)
      else $error("bus still driven with select high");
endmodule // psp_ctrl_chk

bind parallel_slave_port_ctrl psp_ctrl_chk u_chk (
   .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .data_out(data_out), .data_oe(data_oe),
   .ctrl_pin_in(ctrl_pin_in), .ctrl_pin_oe(ctrl_pin_oe)
);

`default_nettype wire

// ==== tb/parallel_slave_port_ctrl_tb.sv ====
// self-checking bench for the host port controller
`timescale 1ns/1ps
`default_nettype none

module parallel_slave_port_ctrl_tb
   import psp_pkg::*;
;
   // *******
   // harness
   // *******
   logic       sys_clk   = 1'b0;
   logic       rst       = 1'b1;
   logic [7:0] reg_addr  = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr    = 1'b0;
   logic       reg_rd    = 1'b0;
   logic [7:0] reg_rdata, data_in, data_out, data_oe;
   logic [2:0] ctrl_pin_in, ctrl_pin_out, ctrl_pin_oe;
   logic       irq;
   int         bad_count   = 0;
   int         comparisons = 0;

   parallel_slave_port_ctrl dut (
      .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe), .ctrl_pin_in(ctrl_pin_in),
      .ctrl_pin_out(ctrl_pin_out), .ctrl_pin_oe(ctrl_pin_oe)
   );
   host_cpu_model host (
      .sys_clk(sys_clk), .data_out(data_out), .data_oe(data_oe),
      .ctrl_pin_in(ctrl_pin_in), .data_in(data_in)
   );

   // 125 MHz
   always #4 sys_clk = ~sys_clk;

   task automatic chk(input string what, input byte_t exp, input byte_t got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one-cycle strobes; #1 lets the taking edge land
   task automatic wr(input byte_t a, input byte_t d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
      #1;
   endtask
   task automatic rd(input byte_t a, input byte_t exp, input string what);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1;
      chk(what, exp, reg_rdata);
   endtask

   task automatic t_reset();
      rd(8'h89, 8'h07, "stat");
      rd(8'h0C, 8'h00, "irqs");
      rd(8'h8C, 8'h00, "mask");
      rd(8'h55, 8'h00, "none");
      chk("pin_oe", 8'h00, {5'h0, ctrl_pin_oe});
   endtask

   task automatic t_status_write();
      wr(8'h89, 8'hE8);
      rd(8'h89, 8'h00, "stat");
      chk("pin_oe", 8'h07, {5'h0, ctrl_pin_oe});
      wr(8'h89, 8'h07);
   endtask

   // gpio mode: data direction, control pin latch and pin readback
   task automatic t_gpio_pins();
      rd(8'h88, 8'hFF, "ddir");
      wr(8'h88, 8'h00);
      chk("data_oe", 8'hFF, data_oe);
      wr(8'h09, 8'h05);
      chk("pin_out", 8'h05, {5'h0, ctrl_pin_out});
      rd(8'h09, 8'h07, "pins");
      wr(8'h88, 8'hFF);
      chk("data_oe", 8'h00, data_oe);
   endtask

   task automatic t_write_path();
      wr(8'h89, 8'h17);
      wr(8'h8C, 8'h80);
      host.write_byte(8'hA5, 1'b1);
      chk("irq", 8'h01, {7'h0, irq});
      rd(8'h89, 8'h97, "stat");
      rd(8'h08, 8'hA5, "data");
      rd(8'h89, 8'h17, "stat");
      rd(8'h0C, 8'h80, "irqs");
      chk("irq", 8'h00, {7'h0, irq});
   endtask

   task automatic t_overrun();
      host.write_byte(8'h11, 1'b1);
      host.write_byte(8'h22, 1'b1);
      rd(8'h89, 8'hB7, "stat");
      rd(8'h08, 8'h22, "data");
      wr(8'h89, 8'h37);
      rd(8'h89, 8'h37, "stat");
      rd(8'h0C, 8'h80, "irqs");
      wr(8'h89, 8'h27);
      host.write_byte(8'h33, 1'b1);
      rd(8'h89, 8'h27, "stat");
      rd(8'h0C, 8'h00, "irqs");
      rd(8'h08, 8'hCC, "pins");
      wr(8'h89, 8'h07);
      rd(8'h89, 8'h07, "stat");
   endtask

   task automatic t_read_path();
      byte_t q;
      logic  drv;
      wr(8'h89, 8'h17);
      wr(8'h8C, 8'h00);
      wr(8'h08, 8'h3C);
      rd(8'h89, 8'h57, "stat");
      host.read_byte(q, drv, 1'b1);
      chk("bus", 8'h3C, q);
      chk("oe", 8'h01, {7'h0, drv});
      rd(8'h89, 8'h17, "stat");
      chk("irq", 8'h00, {7'h0, irq});
      wr(8'h8C, 8'h80);
      chk("irq", 8'h01, {7'h0, irq});
      rd(8'h0C, 8'h80, "irqs");
      chk("irq", 8'h00, {7'h0, irq});
   endtask

   task automatic t_no_select();
      byte_t q;
      logic  drv;
      host.write_byte(8'h5A, 1'b0);
      rd(8'h89, 8'h17, "stat");
      host.read_byte(q, drv, 1'b0);
      chk("oe", 8'h00, {7'h0, drv});
      rd(8'h0C, 8'h00, "irqs");
   endtask

   task automatic finish_test();
      if (bad_count == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // reset for three cycles, then the scenarios
   initial begin
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_status_write();
      t_gpio_pins();
      t_write_path();
      t_overrun();
      t_read_path();
      t_no_select();
      finish_test();
   end
endmodule // parallel_slave_port_ctrl_tb

`default_nettype wire
